// ### hw/sbtc_pkg.sv
package sbtc_pkg;
	// ****************************************************
	// Register map (word indexes: each byte address is four times the index, so all are word aligned)
	// ****************************************************
	localparam logic [7:0] IDX_COUNT_LOW = 8'h0E;
	localparam logic [7:0] IDX_COUNT_HIGH = 8'h0F;
	localparam logic [7:0] IDX_CONTROL = 8'h10;
	localparam logic [7:0] IDX_STATUS = 8'h11;
	localparam logic [7:0] IDX_GATE_CFG = 8'h12;
	localparam int ADDR_W = 10;
	localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW = ADDR_W'(4 * IDX_COUNT_LOW);
	localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = ADDR_W'(4 * IDX_COUNT_HIGH);
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = ADDR_W'(4 * IDX_CONTROL);
	localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(4 * IDX_STATUS);
	localparam logic [ADDR_W-1:0] ADDR_GATE_CFG = ADDR_W'(4 * IDX_GATE_CFG);
	// ****************************************************
	// Control register fields and reset value
	// ****************************************************
	localparam int BIT_COUNT_ON = 0;
	localparam int BIT_CLOCK_SOURCE = 1;
	localparam int BIT_SYNC_DISABLE_N = 2;
	localparam int BIT_CRYSTAL_EN = 3;
	localparam int BIT_PRESCALE_LO = 4;
	localparam int BIT_GATE_ENABLE = 6;
	localparam int BIT_GATE_INVERT = 7;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	// Status: bit0 overflow flag (write one to clear)
	localparam int BIT_OVERFLOW = 0;
	// Gate config: bit0 selects comparator output as gate source
	localparam int BIT_GATE_SRC = 0;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	typedef struct packed {
		logic gate_invert;
		logic gate_enable;
		logic [1:0] prescale_select;
		logic crystal_osc_enable;
		logic sync_disable_n;
		logic clock_source_select;
		logic count_on;
	} sbtc_control_s;
	typedef enum logic [1:0] {
		SBTC_ARMED = 2'b00,
		SBTC_NEED_FALL = 2'b01
	} sbtc_edge_e;
endpackage

// ### hw/sbtc_timer.sv
// Function
// - Internal clock advances count once every N instruction cycles.
// - External clock advances count on rising edges, after prescaling.
// - External clock synchronised or taken direct, chosen by sync_disable_n.
// - Need a falling edge first after enable, count write, high-low change.
// - Prescaler divides by 1, 2, 4 or 8 per prescale_select.
// - Prescaler unreadable; cleared by any count byte write.
// - crystal_osc_enable starts crystal oscillator; runs during sleep.
// - With crystal on, pin 4/5 directions forced input, ports read zero.
// - Unsynchronised counting continues in sleep; overflow wakes core.
// - Sync mode change may lose or add one count.
// - Reading either count byte while counting returns a clean byte.
// - Count held as low and high byte at consecutive addresses.
// - Gate applied only when gate_enable is set.
// - gate_invert inverts the selected gate source.
//
// Added by the designer: register access over AHB-Lite.
module sbtc_timer #(
	parameter int CYCLE_DIV = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hsel,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic ext_count_clock,
	input wire logic gate_pin_n,
	input wire logic comparator_out,
	input wire logic sleep,
	input wire logic dir_pin4_sw,
	input wire logic dir_pin5_sw,
	input wire logic port_pin4_in,
	input wire logic port_pin5_in,
	output logic dir_pin4,
	output logic dir_pin5,
	output logic port_pin4,
	output logic port_pin5,
	output logic crystal_osc_run,
	output logic overflow_flag,
	output logic wake
);
	// ****************************************************
	// Bus slave
	// ****************************************************
	sbtc_pkg::sbtc_control_s ctrl_reg;
	logic gate_src_reg;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic ovf_reg;
	logic wr_pend_reg;
	logic [sbtc_pkg::ADDR_W-1:0] addr_reg;
	logic rd_pend_reg;
	logic wr_low, wr_high, wr_ctrl, wr_stat, wr_gate;
	logic [7:0] wbyte;

	// Always ready, always OKAY: data phase completes in one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= '0;
		end else if (hready) begin
			wr_pend_reg <= hsel && htrans == sbtc_pkg::HTRANS_NONSEQ && hwrite;
			rd_pend_reg <= hsel && htrans == sbtc_pkg::HTRANS_NONSEQ && !hwrite;
			addr_reg <= haddr[sbtc_pkg::ADDR_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign wbyte = hwdata[7:0];
	assign wr_low = wr_pend_reg && addr_reg == sbtc_pkg::ADDR_COUNT_LOW;
	assign wr_high = wr_pend_reg && addr_reg == sbtc_pkg::ADDR_COUNT_HIGH;
	assign wr_ctrl = wr_pend_reg && addr_reg == sbtc_pkg::ADDR_CONTROL;
	assign wr_stat = wr_pend_reg && addr_reg == sbtc_pkg::ADDR_STATUS;
	assign wr_gate = wr_pend_reg && addr_reg == sbtc_pkg::ADDR_GATE_CFG;

	// Read data registered in the address phase so it stands through data phase
	// clean byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans == sbtc_pkg::HTRANS_NONSEQ &&
				!hwrite) begin
			unique case (haddr[sbtc_pkg::ADDR_W-1:0])
				sbtc_pkg::ADDR_COUNT_LOW: hrdata <= {24'h00_0000, count_reg[7:0]};
				sbtc_pkg::ADDR_COUNT_HIGH: hrdata <= {24'h00_0000, count_reg[15:8]};
				sbtc_pkg::ADDR_CONTROL: hrdata <= {24'h00_0000, ctrl_reg};
				sbtc_pkg::ADDR_STATUS: hrdata <= {31'h0000_0000, ovf_reg};
				sbtc_pkg::ADDR_GATE_CFG: hrdata <= {31'h0000_0000, gate_src_reg};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************
	// Control registers
	// ****************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= sbtc_pkg::CONTROL_RESET;
			gate_src_reg <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= sbtc_pkg::sbtc_control_s'(wbyte);
			if (wr_gate)
				gate_src_reg <= hwdata[sbtc_pkg::BIT_GATE_SRC];
		end
	end

	// ****************************************************
	// Clock source, sync and first-falling-edge guard
	// ****************************************************
	logic ext_s1, ext_s2, ext_prev;
	logic ext_src, ext_rise, ext_fall;
	logic on_prev;
	sbtc_pkg::sbtc_edge_e edge_reg;

	// both paths; direct path is taken straight from the pin with no flop, sync path after two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_prev <= 1'b0;
			on_prev <= 1'b0;
		end else begin
			ext_s1 <= ext_count_clock;
			ext_s2 <= ext_s1;
			ext_prev <= ext_src;
			on_prev <= ctrl_reg.count_on;
		end
	end
	// Direct path samples pin as-is; a mode change may drop or add one edge
	// accepted glitch
	assign ext_src = ctrl_reg.sync_disable_n ? ext_count_clock : ext_s2;
	assign ext_rise = ext_src && !ext_prev;
	assign ext_fall = !ext_src && ext_prev;

	// arm only after a falling edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			edge_reg <= sbtc_pkg::SBTC_NEED_FALL;
		end else if (wr_low || wr_high ||
				(ctrl_reg.count_on && !on_prev)) begin
			edge_reg <= sbtc_pkg::SBTC_NEED_FALL;
		end else begin
			unique case (edge_reg)
				sbtc_pkg::SBTC_NEED_FALL:
					if (ext_fall)
						edge_reg <= sbtc_pkg::SBTC_ARMED;
				sbtc_pkg::SBTC_ARMED:
					edge_reg <= sbtc_pkg::SBTC_ARMED;
				// Illegal codes fall back to the safe waiting state
				default:
					edge_reg <= sbtc_pkg::SBTC_NEED_FALL;
			endcase
		end
	end

	// ****************************************************
	// Instruction-cycle tick, gate and prescaler
	// ****************************************************
	logic [$clog2(CYCLE_DIV)-1:0] cyc_reg;
	logic cyc_tick, gate_ok, src_tick, pre_tick;
	logic [2:0] pre_reg;
	logic [2:0] pre_mask;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cyc_reg <= '0;
		else
			cyc_reg <= cyc_reg + 1'b1;
	end
	assign cyc_tick = cyc_reg == '0;

	assign gate_ok = !ctrl_reg.gate_enable ||
		((gate_src_reg ? comparator_out : !gate_pin_n) ^ ctrl_reg.gate_invert);

	assign src_tick = ctrl_reg.clock_source_select ?
		(ext_rise && edge_reg == sbtc_pkg::SBTC_ARMED) : cyc_tick;

	assign pre_mask = 3'((4'b0001 << ctrl_reg.prescale_select) - 4'b0001);
	assign pre_tick = src_tick && ((pre_reg & pre_mask) == pre_mask);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pre_reg <= 3'b000;
		else if (wr_low || wr_high)
			pre_reg <= 3'b000;
		else if (ctrl_reg.count_on && gate_ok && src_tick)
			pre_reg <= pre_reg + 3'b001;
	end

	// ****************************************************
	// Count pair and overflow
	// ****************************************************
	logic cnt_inc;
	// sleep does not stop unsynchronised external counting
	assign cnt_inc = ctrl_reg.count_on && gate_ok && pre_tick &&
		(!sleep || (ctrl_reg.clock_source_select && ctrl_reg.sync_disable_n));

	always_comb begin
		count_next = count_reg;
		if (cnt_inc)
			count_next = count_reg + 16'h0001;
		if (wr_low)
			count_next[7:0] = wbyte;
		if (wr_high)
			count_next[15:8] = wbyte;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			count_reg <= sbtc_pkg::COUNT_RESET;
		else
			count_reg <= count_next;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ovf_reg <= 1'b0;
		else if (cnt_inc && count_reg == 16'hFFFF)
			ovf_reg <= 1'b1;
		else if (wr_stat && hwdata[sbtc_pkg::BIT_OVERFLOW])
			ovf_reg <= 1'b0;
	end

	// ****************************************************
	// Pin overrides and outputs
	// ****************************************************
	// oscillator enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_pin4 <= 1'b1;
			dir_pin5 <= 1'b1;
			port_pin4 <= 1'b0;
			port_pin5 <= 1'b0;
			crystal_osc_run <= 1'b0;
			overflow_flag <= 1'b0;
			wake <= 1'b0;
		end else begin
			crystal_osc_run <= ctrl_reg.crystal_osc_enable;
			dir_pin4 <= ctrl_reg.crystal_osc_enable | dir_pin4_sw;
			dir_pin5 <= ctrl_reg.crystal_osc_enable | dir_pin5_sw;
			port_pin4 <= !ctrl_reg.crystal_osc_enable & port_pin4_in;
			port_pin5 <= !ctrl_reg.crystal_osc_enable & port_pin5_in;
			overflow_flag <= ovf_reg;
			wake <= sleep && ovf_reg;
		end
	end

	// ****************************************************
	// Assertions
	// ****************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_wr_low;
		wr_low;
	endsequence

	ovf_sets_a: assert property (cnt_inc && count_reg == 16'hFFFF |=> ovf_reg)
		else $error("overflow flag not set");
	ovf_sticky_a: assert property ($rose(ovf_reg) |-> ovf_reg [*1] ##1
		(ovf_reg || $past(wr_stat)))
		else $error("overflow flag dropped");
	pre_clear_a: assert property (s_wr_low |=> pre_reg == 3'b000)
		else $error("prescaler not cleared");
	need_fall_a: assert property (wr_high |=>
		!cnt_inc || !ctrl_reg.clock_source_select)
		else $error("counted without falling edge");
	count_off_a: assert property (!ctrl_reg.count_on && !wr_low && !wr_high
		|=> count_reg == $past(count_reg))
		else $error("counted while off");
	dir_force_a: assert property (ctrl_reg.crystal_osc_enable
		|=> dir_pin4 && dir_pin5 && !port_pin4 && !port_pin5)
		else $error("pins not forced");
	div_one_a: assert property (ctrl_reg.prescale_select == 2'b00 && src_tick
		|-> pre_tick)
		else $error("divide by one missed");
	gate_off_a: assert property (ctrl_reg.gate_enable &&
		!((gate_src_reg ? comparator_out : !gate_pin_n) ^ ctrl_reg.gate_invert)
		|-> !cnt_inc)
		else $error("counted with gate closed");
	int_tick_a: assert property (!ctrl_reg.clock_source_select &&
		cnt_inc |=> !cnt_inc)
		else $error("internal ticks too close");
endmodule

// ### sim/sbtc_pulse_src.sv
// ****************************************************
// External count source
// ****************************************************
module sbtc_pulse_src (
	output logic ext_count_clock
);
	timeunit 1ns;
	timeprecision 1ps;
	// Line rests low between bursts, like a stopped source
	initial begin
		ext_count_clock = 1'b0;
	end
	// Burst of k rising edges, phase unrelated to the bus clock
	task automatic burst(input int k, input int half_ns);
		repeat (k) begin
			#(half_ns) ext_count_clock = 1'b1;
			#(half_ns) ext_count_clock = 1'b0;
		end
	endtask
endmodule

// ### sim/sbtc_timer_tb.sv
module sbtc_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CD = 4;
	localparam logic [9:0] LOW = sbtc_pkg::ADDR_COUNT_LOW;
	localparam logic [9:0] HIGH = sbtc_pkg::ADDR_COUNT_HIGH;
	localparam logic [9:0] CTRL = sbtc_pkg::ADDR_CONTROL;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata, rd, c1, dv;
	logic hreadyout, hresp, ext_clk, dir4, dir5, port4, port5, xrun, ovf, wake;
	logic cmp = 1'b0;
	logic sleep = 1'b0;
	logic [3:0] pins = 4'h0;
	logic [31:0] d [2][2];
	int n_fail = 0;
	int total_checks = 0;
	int k;
	sbtc_pulse_src i_src (.ext_count_clock(ext_clk));
	sbtc_timer #(.CYCLE_DIV(CD)) i_dut (.clk(clk), .rst_n(rst_n),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hsel(1'b1), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_count_clock(ext_clk),
		.gate_pin_n(1'b1), .comparator_out(cmp), .sleep(sleep),
		.dir_pin4_sw(pins[0]), .dir_pin5_sw(pins[1]),
		.port_pin4_in(pins[2]), .port_pin5_in(pins[3]), .dir_pin4(dir4),
		.dir_pin5(dir5), .port_pin4(port4), .port_pin5(port5),
		.crystal_osc_run(xrun), .overflow_flag(ovf), .wake(wake));
	// ****************************************************
	// Clock, checks and bus tasks
	// ****************************************************
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic summarize();
		if (n_fail == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input int exp, input logic [31:0] got);
		total_checks++;
		if (got !== 32'(exp)) begin
			n_fail++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// Bounded wait for hready; a hung slave ends the run
	task automatic wait_rdy(inout int t);
		do begin
			@(posedge clk);
			t++;
		end while (hreadyout !== 1'b1 && t < 50);
		if (t >= 50) begin
			n_fail++;
			summarize();
		end
	endtask
	// One single word transfer; read data lands in rd
	task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] v);
		int t;
		t = 0;
		@(posedge clk);
		haddr <= {22'h00_0000, a};
		htrans <= sbtc_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy(t);
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, v};
		wait_rdy(t);
		rd = hrdata;
	endtask
	// Model: first edge only arms the guard, the rest pass the prescaler
	function automatic int model_ext(input int edges, input int m);
		int pre;
		int cnt;
		pre = 0;
		cnt = 0;
		for (int e = 1; e < edges; e++) begin
			pre++;
			if (pre == (1 << m)) begin
				pre = 0;
				cnt++;
			end
		end
		return cnt;
	endfunction
	// Count advance between two low-byte samples exactly cyc edges apart
	task automatic delta(input int cyc, output logic [31:0] dv);
		bus(LOW, 1'b0, 8'h00);
		c1 = rd;
		repeat (cyc - 3) @(posedge clk);
		bus(LOW, 1'b0, 8'h00);
		dv = (rd - c1) & 32'h0000_00FF;
	endtask
	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		void'($urandom(32'hebdf));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		bus(CTRL, 1'b0, 8'h00);
		chk("control reset", 0, rd);
		bus(LOW, 1'b0, 8'h00);
		chk("count low reset", 0, rd);
		bus(10'h3FC, 1'b0, 8'h00);
		chk("unmapped read", 0, rd);
		// Internal clock at every prescale ratio
		for (int p = 0; p < 4; p++) begin
			bus(CTRL, 1'b1, {2'b00, 2'(p), 4'h1});
			delta(32 * CD * (1 << p), dv);
			chk("internal delta", 32, dv);
		end
		bus(CTRL, 1'b1, 8'h00);
		delta(64, dv);
		chk("stopped delta", 0, dv);
		// External edges, sync and async, prescaler left with a residue
		for (int m = 0; m < 4; m++) begin
			bus(CTRL, 1'b1, 8'h00);
			bus(HIGH, 1'b1, 8'h00);
			bus(LOW, 1'b1, 8'h00);
			bus(CTRL, 1'b1, {2'b00, 2'(m), 1'b0, 1'(m), 2'b11});
			k = 4 + int'($urandom % 12);
			i_src.burst(k, 123);
			repeat (4) @(posedge clk);
			bus(LOW, 1'b0, 8'h00);
			chk("external count", model_ext(k, m), rd);
		end
		// Async counting through sleep to overflow
		bus(CTRL, 1'b1, 8'h00);
		bus(HIGH, 1'b1, 8'hFF);
		bus(LOW, 1'b1, 8'hFE);
		sleep <= 1'b1;
		bus(CTRL, 1'b1, 8'h07);
		i_src.burst(3, 123);
		repeat (4) @(posedge clk);
		chk("overflow flag", 1, 32'(ovf));
		chk("wake", 1, 32'(wake));
		// no edges arrive between the two byte reads
		bus(LOW, 1'b0, 8'h00);
		chk("wrapped low", 0, rd);
		bus(HIGH, 1'b0, 8'h00);
		chk("wrapped high", 0, rd);
		chk("flag sticky", 1, 32'(ovf));
		sleep <= 1'b0;
		bus(sbtc_pkg::ADDR_STATUS, 1'b1, 8'h01);
		repeat (2) @(posedge clk);
		chk("flag cleared", 0, 32'(ovf));
		// Gate from comparator, both polarities
		bus(sbtc_pkg::ADDR_GATE_CFG, 1'b1, 8'h01);
		for (int i = 0; i < 2; i++) begin
			for (int c = 0; c < 2; c++) begin
				bus(CTRL, 1'b1, {1'(i), 7'h41});
				cmp <= 1'(c);
				repeat (4) @(posedge clk);
				delta(32 * CD, d[i][c]);
			end
			chk("gate sum", 32, d[i][0] + d[i][1]);
			chk("gate blocks", 0, d[i][0] * d[i][1]);
		end
		chk("gate invert", 0, d[1][0] ^ d[0][1]);
		// Pin takeover by the crystal oscillator
		bus(CTRL, 1'b1, 8'h00);
		pins <= 4'($urandom);
		repeat (3) @(posedge clk);
		chk("pins free", 32'(pins), 32'({port5, port4, dir5, dir4}));
		// primary clock taken as internal, crystal use allowed
		// oscillator alone first, timer left off during start-up
		bus(CTRL, 1'b1, 8'h08);
		repeat (3) @(posedge clk);
		chk("pins forced", 3, 32'({port5, port4, dir5, dir4}));
		chk("crystal run", 1, 32'(xrun));
		summarize();
	end
endmodule
